/* design/vrc_defs.vh */
`ifndef VRC_DEFS_VH
`define VRC_DEFS_VH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define VRC_ADDR_CTRL       8'h00
`define VRC_ADDR_TEMP       8'h04

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define VRC_BIT_REF_EN      7
`define VRC_BIT_READY       6
`define VRC_BIT_TS_EN       5
`define VRC_BIT_TS_RNG      4
`define VRC_CDA_HI          3
`define VRC_CDA_LO          2
`define VRC_ADC_HI          1
`define VRC_ADC_LO          0
`define VRC_CTRL_RESET      8'h00
`define VRC_WR_MASK         8'hBF

// ---------------------------------------------------------------
// temperature sampling status fields
// ---------------------------------------------------------------
`define VRC_BIT_CH_SEL      0
`define VRC_BIT_CONV_OK     1

// ---------------------------------------------------------------
// gain codes
// ---------------------------------------------------------------
`define VRC_GAIN_OFF        2'h0
`define VRC_GAIN_X1         2'h1
`define VRC_GAIN_X2         2'h2
`define VRC_GAIN_X4         2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define VRC_CLK_MHZ         250
`define VRC_SETTLE_US       25
`define VRC_SETTLE_CYC      (`VRC_SETTLE_US * `VRC_CLK_MHZ)
`define VRC_ACQ_US          200
`define VRC_ACQ_CYC         (`VRC_ACQ_US * `VRC_CLK_MHZ)

`endif

/* design/vrc_gain_dec.v */
`timescale 1ns/100ps
`include "vrc_defs.vh"

// ---------------------------------------------------------------
// two-bit gain code to buffer enable and one-hot gain
// ---------------------------------------------------------------
module vrc_gain_dec (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire [1:0] code_i,
	output reg        buf_on_o,
	output reg  [2:0] gain_o
);

	function [2:0] gain_of;
		input [1:0] c;
		begin
			case (c)
				`VRC_GAIN_X4: gain_of = 3'h4;
				`VRC_GAIN_X2: gain_of = 3'h2;
				`VRC_GAIN_X1: gain_of = 3'h1;
				default:      gain_of = 3'h0;
			endcase
		end
	endfunction

	always @(posedge clk_i) begin
		if (rst_i) begin
			buf_on_o <= 1'b0;
			gain_o   <= 3'h0;
		end else begin
			buf_on_o <= (code_i != `VRC_GAIN_OFF);
			gain_o   <= gain_of(code_i);
		end
	end

endmodule

/* design/vrc_timer.v */
`timescale 1ns/100ps

// ---------------------------------------------------------------
// down counter: done once count cycles have passed since start
// ---------------------------------------------------------------
module vrc_timer #(
	parameter integer COUNT = 16
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire start_i,
	input  wire run_i,
	output reg  done_o
);

	localparam integer W = (COUNT < 2) ? 1 : $clog2(COUNT + 1);
	localparam [W-1:0] LOAD = COUNT[W-1:0];

	reg [W-1:0] cnt_reg;

	always @(posedge clk_i) begin
		// reload while idle so the count starts the moment run rises
		if (rst_i || !run_i) begin
			cnt_reg <= LOAD;
			done_o  <= 1'b0;
		end else if (start_i) begin
			cnt_reg <= LOAD;
			done_o  <= 1'b0;
		end else if (cnt_reg > {{(W-1){1'b0}}, 1'b1}) begin
			cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
		end else begin
			cnt_reg <= {W{1'b0}};
			done_o  <= 1'b1;
		end
	end

endmodule

/* design/vrc_top.v */
`timescale 1ns/100ps
`include "vrc_defs.vh"

module vrc_top #(
	parameter         READY_ALWAYS = 1'b1,
	parameter integer SETTLE_CYC   = `VRC_SETTLE_CYC,
	parameter integer ACQ_CYC      = `VRC_ACQ_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         ref_on_o,
	output reg         ts_on_o,
	output reg         ts_high_range_o,
	output reg         ts_to_adc_o,
	output wire        adc_buf_on_o,
	output wire [2:0]  adc_gain_o,
	output wire        cda_buf_on_o,
	output wire [2:0]  cda_gain_o
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg  [7:0] ctrl_reg;
	reg        ch_sel_reg;
	wire       settled;
	wire       acq_ok;
	wire       ready;
	wire       req;
	wire       wr_ctrl;
	wire       wr_temp;

	assign req     = cyc_i && stb_i && !ack_o;
	assign wr_ctrl = req && we_i && sel_i[0] && (adr_i == `VRC_ADDR_CTRL);
	assign wr_temp = req && we_i && sel_i[0] && (adr_i == `VRC_ADDR_TEMP);

	// ready masks: forced high on this variant, else gated by settling
	assign ready = READY_ALWAYS ? 1'b1 :
		(ctrl_reg[`VRC_BIT_REF_EN] && settled);

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg   <= `VRC_CTRL_RESET;
			ch_sel_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= dat_i[7:0] & `VRC_WR_MASK;
			if (wr_temp)
				ch_sel_reg <= dat_i[`VRC_BIT_CH_SEL];
		end
	end

	// ---------------------------------------------------------------
	// settling and acquisition timers
	// ---------------------------------------------------------------
	vrc_timer #(
		.COUNT(SETTLE_CYC)
	) u_settle (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.start_i(1'b0),
		.run_i  (ctrl_reg[`VRC_BIT_REF_EN]),
		.done_o (settled)
	);

	// status only: software is trusted to honour the wait itself
	vrc_timer #(
		.COUNT(ACQ_CYC)
	) u_acq (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.start_i(1'b0),
		.run_i  (ch_sel_reg && ctrl_reg[`VRC_BIT_TS_EN]),
		.done_o (acq_ok)
	);

	// ---------------------------------------------------------------
	// gain stages
	// ---------------------------------------------------------------
	vrc_gain_dec u_cda (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.code_i  (ctrl_reg[`VRC_CDA_HI:`VRC_CDA_LO]),
		.buf_on_o(cda_buf_on_o),
		.gain_o  (cda_gain_o)
	);

	vrc_gain_dec u_adc (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.code_i  (ctrl_reg[`VRC_ADC_HI:`VRC_ADC_LO]),
		.buf_on_o(adc_buf_on_o),
		.gain_o  (adc_gain_o)
	);

	// ---------------------------------------------------------------
	// analog controls and bus answer
	// ---------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_on_o        <= 1'b0;
			ts_on_o         <= 1'b0;
			ts_high_range_o <= 1'b0;
			ts_to_adc_o     <= 1'b0;
			ack_o           <= 1'b0;
			dat_o           <= 32'h00000000;
		end else begin
			ref_on_o        <= ctrl_reg[`VRC_BIT_REF_EN];
			ts_on_o         <= ctrl_reg[`VRC_BIT_TS_EN];
			ts_high_range_o <= ctrl_reg[`VRC_BIT_TS_RNG];
			ts_to_adc_o     <= ch_sel_reg && ctrl_reg[`VRC_BIT_TS_EN];
			ack_o           <= req;
			dat_o           <= 32'h00000000;
			if (req && !we_i) begin
				case (adr_i)
					`VRC_ADDR_CTRL:
						dat_o <= {24'h000000, ctrl_reg[7], ready, ctrl_reg[5:0]};
					`VRC_ADDR_TEMP:
						dat_o <= {30'h00000000, acq_ok, ch_sel_reg};
					default:
						dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

/* sim/vrc_asserts.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module vrc_asserts (
	input logic        clk_i,
	input logic        rst_i,
	input logic        cyc_i,
	input logic        stb_i,
	input logic        we_i,
	input logic [7:0]  adr_i,
	input logic [3:0]  sel_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	input logic        ref_on_o,
	input logic        ts_on_o,
	input logic        ts_high_range_o,
	input logic        cda_buf_on_o,
	input logic [2:0]  cda_gain_o,
	input logic        adc_buf_on_o,
	input logic [2:0]  adc_gain_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	function automatic [3:0] gx(input [1:0] c);
		gx = (c == 2'h0) ? 4'h0 : {1'b1, 3'h1 << (c - 2'h1)};
	endfunction
	// write data is still held in the ack cycle, so $past sees it
	sequence s_wr;
		ack_o && we_i && adr_i == 8'h00 && sel_i[0];
	endsequence
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	property p_ref; s_wr |=> ref_on_o == $past(dat_i[7]); endproperty
	property p_ts; s_wr |=> ts_on_o == $past(dat_i[5]); endproperty
	property p_rng; s_wr |=> ts_high_range_o == $past(dat_i[4]); endproperty
	property p_cda;
		s_wr |=> ##1 {cda_buf_on_o, cda_gain_o} == gx($past(dat_i[3:2], 2));
	endproperty
	property p_adc;
		s_wr |=> ##1 {adc_buf_on_o, adc_gain_o} == gx($past(dat_i[1:0], 2));
	endproperty
	property p_rdy;
		ack_o && !we_i && adr_i == 8'h00 |-> dat_o[6] && dat_o[31:8] == 24'h0;
	endproperty
	property p_rst;
		$fell(rst_i) |-> !ack_o && !ref_on_o && !ts_on_o && !cda_buf_on_o && !adc_buf_on_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	a_ref: assert property (p_ref) else $error("reference enable wrong");
	a_ts: assert property (p_ts) else $error("indicator enable wrong");
	a_rng: assert property (p_rng) else $error("range select wrong");
	a_cda: assert property (p_cda) else $error("compdac gain wrong");
	a_adc: assert property (p_adc) else $error("converter gain wrong");
	a_rdy: assert property (p_rdy) else $error("ready flag low");
	a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule
bind vrc_top vrc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .ref_on_o(ref_on_o), .ts_on_o(ts_on_o),
	.ts_high_range_o(ts_high_range_o), .cda_buf_on_o(cda_buf_on_o),
	.cda_gain_o(cda_gain_o), .adc_buf_on_o(adc_buf_on_o), .adc_gain_o(adc_gain_o));

/* sim/vrc_top_tb.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// register bench
// ---------------------------------------------------------------
module vrc_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] q;
	wire  [31:0] dat_o;
	wire         ack_o, ref_on_o, ts_on_o, ts_high_range_o, ts_to_adc_o;
	wire         adc_buf_on_o, cda_buf_on_o;
	wire  [2:0]  adc_gain_o, cda_gain_o;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #2 clk_i = ~clk_i;
	// short settle and acquisition counts keep the run brief
	vrc_top #(.SETTLE_CYC(8), .ACQ_CYC(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ref_on_o(ref_on_o),
		.ts_on_o(ts_on_o), .ts_high_range_o(ts_high_range_o), .ts_to_adc_o(ts_to_adc_o),
		.adc_buf_on_o(adc_buf_on_o), .adc_gain_o(adc_gain_o),
		.cda_buf_on_o(cda_buf_on_o), .cda_gain_o(cda_gain_o));
	function automatic [3:0] gx(input [1:0] c);
		gx = (c == 2'h0) ? 4'h0 : {1'b1, 3'h1 << (c - 2'h1)};
	endfunction
	task test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; read data lands in q at the ack edge
	task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task t_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({ref_on_o, ts_on_o, cda_buf_on_o, adc_buf_on_o}, 32'h0);
		wb(1'b0, 8'h00, 32'h0, 4'hF);
		chk(q, 32'h40);
		$display("t_reset done");
	endtask
	task t_fields;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			d = {i[1], i[0], i[0], ~i[1], i[1:0], ~i[1:0]};
			wb(1'b1, 8'h00, {24'h0, d}, 4'h1);
			repeat (2) @(posedge clk_i);
			chk(ref_on_o, d[7]);
			chk(ts_on_o, d[5]);
			chk(ts_high_range_o, d[4]);
			chk({cda_buf_on_o, cda_gain_o}, gx(d[3:2]));
			chk({adc_buf_on_o, adc_gain_o}, gx(d[1:0]));
			wb(1'b0, 8'h00, 32'h0, 4'hF);
			chk(q, {24'h0, d | 8'h40});
		end
		$display("t_fields done");
	endtask
	task t_refuse;
		wb(1'b1, 8'h00, 32'hFF, 4'h0);
		wb(1'b0, 8'h00, 0, 4'hF);
		chk(q, 32'hEC);
		wb(1'b1, 8'h10, 32'hFF, 4'hF);
		wb(1'b0, 8'h10, 0, 4'hF);
		chk(q, 32'h0);
		$display("t_refuse done");
	endtask
	task t_temp;
		wb(1'b1, 8'h00, 32'h20, 4'h1);
		wb(1'b1, 8'h04, 32'h1, 4'h1);
		// acquisition window not yet over: only the select reads back
		wb(1'b0, 8'h04, 32'h0, 4'hF);
		chk(q, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(ts_to_adc_o, 1'b1);
		repeat (20) @(posedge clk_i);
		wb(1'b0, 8'h04, 32'h0, 4'hF);
		chk(q, 32'h3);
		wb(1'b1, 8'h00, 32'h0, 4'h1);
		repeat (2) @(posedge clk_i);
		chk(ts_to_adc_o, 1'b0);
		$display("t_temp done");
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			test_done;
		end
	end
	initial begin
		t_reset;
		t_fields;
		t_refuse;
		t_temp;
		t_reset;
		test_done;
	end
endmodule
